// *** adcoc_top.sv ***
`include "adcoc_regs.svh"

module adcoc_top (
  // Clock, reset, enable
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_clk_en,
  // Register access
  input  wire adcoc_pkg::adcoc_req_t      i_req,
  output logic [7:0]                      o_reg_rdata,
  // Pins
  input  wire logic                       i_external_output_enable_pin,
  input  wire logic                       i_serial_clock_format_select_pin,
  input  wire logic                       i_ext_pin_mode,
  // Converter core data
  input  wire logic                       i_conv_valid,
  input  wire logic [`ADCOC_DATA_W-1:0]   i_conv_data,
  // Output drivers
  output logic [`ADCOC_DATA_W-1:0]        o_data,
  output logic                            o_data_oe,
  output logic                            o_data_output_clock,
  output logic [1:0]                      o_drv_cfg,
  output logic [1:0]                      o_vref_sel
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic [2:0] nxt_pin_meta;
  logic [2:0] nxt_pin_sync;
  logic       ext_oe;
  logic       fsel_pin;
  logic       pin_mode;

  // Two stages; only the second stage is read
  always_comb begin
    nxt_pin_meta = {i_ext_pin_mode, i_serial_clock_format_select_pin,
                    i_external_output_enable_pin};
    nxt_pin_sync = pin_meta_ff;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else if (i_clk_en) begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  assign ext_oe   = pin_sync_ff[0];
  assign fsel_pin = pin_sync_ff[1];
  assign pin_mode = pin_sync_ff[2];

  // ****************************************
  // Register bank
  // ****************************************
  adcoc_pkg::adcoc_cfg_t cfg_ff;
  adcoc_pkg::adcoc_cfg_t nxt_cfg;
  logic [7:0]            rdata_ff;
  logic [7:0]            nxt_rdata;
  logic [7:0]            wd;
  logic [7:0]            rd_test;
  logic [7:0]            rd_ofs;
  logic [7:0]            rd_fmt;
  logic [7:0]            rd_pol;
  logic [7:0]            rd_vref;

  // Readback images; open bits are forced to zero
  always_comb begin
    rd_test = 8'h00;
    rd_test[`ADCOC_TEST_LONG_RST]        = cfg_ff.long_rst;
    rd_test[`ADCOC_TEST_SHORT_RST]       = cfg_ff.short_rst;
    rd_test[`ADCOC_TEST_MODE_MSB:0]      = cfg_ff.test;
    rd_ofs  = 8'h00;
    rd_ofs[`ADCOC_OFS_MSB:0]             = cfg_ff.offset;
    rd_fmt  = 8'h00;
    rd_fmt[`ADCOC_DRV_MSB:`ADCOC_DRV_LSB] = cfg_ff.drv_cfg;
    rd_fmt[`ADCOC_DIS_BIT]               = cfg_ff.out_dis;
    rd_fmt[`ADCOC_INV_BIT]               = cfg_ff.invert;
    rd_fmt[`ADCOC_FMT_MSB:0]             = cfg_ff.fmt;
    rd_pol  = 8'h00;
    rd_pol[`ADCOC_POL_BIT]               = cfg_ff.clk_inv;
    rd_vref = 8'h00;
    rd_vref[`ADCOC_VREF_MSB:`ADCOC_VREF_LSB] = cfg_ff.vref_sel;
  end

  // Writes store masked data; reads answer one cycle later
  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_rdata = rdata_ff;
    wd        = i_req.wdata;
    if (i_req.wr) begin
      case (i_req.addr)
        `ADCOC_ADDR_TEST: begin
          wd                = wd & `ADCOC_MASK_TEST;
          nxt_cfg.long_rst  = wd[`ADCOC_TEST_LONG_RST];
          nxt_cfg.short_rst = wd[`ADCOC_TEST_SHORT_RST];
          nxt_cfg.test      = adcoc_pkg::adcoc_test_t'(wd[`ADCOC_TEST_MODE_MSB:0]);
        end
        `ADCOC_ADDR_OFFSET: begin
          wd             = wd & `ADCOC_MASK_OFFSET;
          nxt_cfg.offset = wd[`ADCOC_OFS_MSB:0];
        end
        `ADCOC_ADDR_FORMAT: begin
          wd              = wd & `ADCOC_MASK_FORMAT;
          nxt_cfg.drv_cfg = wd[`ADCOC_DRV_MSB:`ADCOC_DRV_LSB];
          nxt_cfg.out_dis = wd[`ADCOC_DIS_BIT];
          nxt_cfg.invert  = wd[`ADCOC_INV_BIT];
          nxt_cfg.fmt     = adcoc_pkg::adcoc_fmt_t'(wd[`ADCOC_FMT_MSB:0]);
        end
        `ADCOC_ADDR_PHASE: begin
          nxt_cfg.clk_inv = wd[`ADCOC_POL_BIT];
        end
        `ADCOC_ADDR_VREF: begin
          nxt_cfg.vref_sel = wd[`ADCOC_VREF_MSB:`ADCOC_VREF_LSB];
        end
        default: begin
          nxt_cfg = cfg_ff; // Unmapped writes are dropped
        end
      endcase
    end
    if (i_req.rd) begin
      case (i_req.addr)
        `ADCOC_ADDR_TEST:   nxt_rdata = rd_test;
        `ADCOC_ADDR_OFFSET: nxt_rdata = rd_ofs;
        `ADCOC_ADDR_FORMAT: nxt_rdata = rd_fmt;
        `ADCOC_ADDR_PHASE:  nxt_rdata = rd_pol;
        `ADCOC_ADDR_VREF:   nxt_rdata = rd_vref;
        default:            nxt_rdata = 8'h00;
      endcase
    end
  end

  // Reset images come from the reset-value constants, except test and fmt, which load TEST_OFF and FMT_OFFS
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_ff.long_rst  <= 1'(`ADCOC_RST_TEST >> `ADCOC_TEST_LONG_RST);
      cfg_ff.short_rst <= 1'(`ADCOC_RST_TEST >> `ADCOC_TEST_SHORT_RST);
      cfg_ff.test      <= adcoc_pkg::TEST_OFF;
      cfg_ff.offset    <= 6'(`ADCOC_RST_OFFSET);
      cfg_ff.drv_cfg   <= 2'(`ADCOC_RST_FORMAT >> `ADCOC_DRV_LSB);
      cfg_ff.out_dis   <= 1'(`ADCOC_RST_FORMAT >> `ADCOC_DIS_BIT);
      cfg_ff.invert    <= 1'(`ADCOC_RST_FORMAT >> `ADCOC_INV_BIT);
      cfg_ff.fmt       <= adcoc_pkg::FMT_OFFS;
      cfg_ff.clk_inv   <= 1'(`ADCOC_RST_PHASE >> `ADCOC_POL_BIT);
      cfg_ff.vref_sel  <= 2'(`ADCOC_RST_VREF >> `ADCOC_VREF_LSB);
      rdata_ff         <= 8'h00;
    end else if (i_clk_en) begin
      cfg_ff   <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Pattern generators
  // ****************************************
  logic [`ADCOC_DATA_W-1:0] long_prbs_pattern;
  logic [`ADCOC_DATA_W-1:0] short_prbs_pattern;

  // Each generator steps once per sample, held at seed while reset bit set
  adcoc_prbs #(
    .LEN   (`ADCOC_LONG_LEN),
    .TAP   (`ADCOC_LONG_TAP),
    .OUT_W (`ADCOC_DATA_W)
  ) u_long_prbs (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_clk_en  (i_clk_en),
    .i_step    (i_conv_valid),
    .i_hold    (cfg_ff.long_rst),
    .o_word    (long_prbs_pattern)
  );

  adcoc_prbs #(
    .LEN   (`ADCOC_SHORT_LEN),
    .TAP   (`ADCOC_SHORT_TAP),
    .OUT_W (`ADCOC_DATA_W)
  ) u_short_prbs (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_clk_en  (i_clk_en),
    .i_step    (i_conv_valid),
    .i_hold    (cfg_ff.short_rst),
    .o_word    (short_prbs_pattern)
  );

  // ****************************************
  // Output data path
  // ****************************************
  logic [`ADCOC_DATA_W-1:0] data_ff;
  logic [`ADCOC_DATA_W-1:0] nxt_data;
  logic                     oe_ff;
  logic                     nxt_oe;
  logic                     oclk_ff;
  logic                     nxt_oclk;
  logic                     phase_ff;
  logic                     nxt_phase;
  logic signed [15:0]       sum;
  logic [`ADCOC_DATA_W-1:0] adj;
  logic [`ADCOC_DATA_W-1:0] pat;
  logic [`ADCOC_DATA_W-1:0] enc;
  adcoc_pkg::adcoc_fmt_t    fmt_eff;

  // Offset add with saturation, so a large offset never wraps the code
  always_comb begin
    sum = $signed({2'b00, i_conv_data})
        + $signed({{10{cfg_ff.offset[`ADCOC_OFS_MSB]}}, cfg_ff.offset});
    if (sum > `ADCOC_SUM_MAX) begin
      adj = `ADCOC_W_POS_FS;
    end else if (sum < `ADCOC_SUM_MIN) begin
      adj = `ADCOC_W_NEG_FS;
    end else begin
      adj = sum[`ADCOC_DATA_W-1:0];
    end
  end

  // Pattern select, format, invert; patterns pass through format too
  always_comb begin
    case (cfg_ff.test)
      adcoc_pkg::TEST_OFF:   pat = adj;
      adcoc_pkg::TEST_MID:   pat = `ADCOC_W_MID;
      adcoc_pkg::TEST_POSFS: pat = `ADCOC_W_POS_FS;
      adcoc_pkg::TEST_NEGFS: pat = `ADCOC_W_NEG_FS;
      adcoc_pkg::TEST_CHK:   pat = phase_ff ? `ADCOC_W_CHK_B : `ADCOC_W_CHK_A;
      adcoc_pkg::TEST_LONG:  pat = long_prbs_pattern;
      adcoc_pkg::TEST_SHORT: pat = short_prbs_pattern;
      adcoc_pkg::TEST_TOG:   pat = phase_ff ? `ADCOC_W_NEG_FS : `ADCOC_W_POS_FS;
      default:               pat = adj;
    endcase
    if (pin_mode) begin
      fmt_eff = fsel_pin ? adcoc_pkg::FMT_TWOS : adcoc_pkg::FMT_OFFS;
    end else begin
      fmt_eff = cfg_ff.fmt;
    end
    case (fmt_eff)
      adcoc_pkg::FMT_TWOS: enc = {~pat[`ADCOC_DATA_W-1], pat[`ADCOC_DATA_W-2:0]};
      adcoc_pkg::FMT_GRAY: enc = pat ^ (pat >> 1);
      default:             enc = pat;
    endcase
    nxt_data  = i_conv_valid ? (enc ^ {`ADCOC_DATA_W{cfg_ff.invert}}) : data_ff;
    nxt_phase = i_conv_valid ? ~phase_ff : phase_ff;
    nxt_oe    = ext_oe & ~cfg_ff.out_dis;
    nxt_oclk  = i_conv_valid ^ cfg_ff.clk_inv;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_ff  <= `ADCOC_W_NEG_FS;
      oe_ff    <= 1'b0;
      oclk_ff  <= 1'b0;
      phase_ff <= 1'b0;
    end else if (i_clk_en) begin
      data_ff  <= nxt_data;
      oe_ff    <= nxt_oe;
      oclk_ff  <= nxt_oclk;
      phase_ff <= nxt_phase;
    end
  end

  assign o_data              = data_ff;
  assign o_data_oe           = oe_ff;
  assign o_data_output_clock = oclk_ff;
  assign o_reg_rdata         = rdata_ff;
  assign o_drv_cfg           = cfg_ff.drv_cfg;
  assign o_vref_sel          = cfg_ff.vref_sel;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  logic plain_path;
  assign plain_path = !cfg_ff.invert && !pin_mode && cfg_ff.fmt == adcoc_pkg::FMT_OFFS;

  ofs_zero_pass_a: assert property (
    i_clk_en && i_conv_valid && plain_path && cfg_ff.test == adcoc_pkg::TEST_OFF
      && cfg_ff.offset == 6'h00 |=> o_data == $past(i_conv_data))
    else $error("zero offset does not pass data");

  mid_test_word_a: assert property (
    i_clk_en && i_conv_valid && plain_path && cfg_ff.test == adcoc_pkg::TEST_MID
      |=> o_data == `ADCOC_W_MID)
    else $error("midscale word wrong");

  tog_test_word_a: assert property (
    i_clk_en && i_conv_valid && cfg_ff.test == adcoc_pkg::TEST_TOG && fmt_eff != adcoc_pkg::FMT_GRAY
      ##1 i_clk_en && i_conv_valid && $stable(cfg_ff) && $stable(fmt_eff)
      |=> o_data == ~$past(o_data))
    else $error("toggle pattern does not alternate");

  out_disable_a: assert property (i_clk_en && cfg_ff.out_dis |=> !o_data_oe)
    else $error("outputs enabled while disabled");

  ext_oe_gate_a: assert property (i_clk_en && !ext_oe |=> !o_data_oe)
    else $error("outputs enabled with pin low");

  invert_word_a: assert property (
    i_clk_en && i_conv_valid && cfg_ff.invert && !pin_mode && cfg_ff.fmt == adcoc_pkg::FMT_OFFS
      && cfg_ff.test == adcoc_pkg::TEST_POSFS |=> o_data == `ADCOC_W_NEG_FS)
    else $error("invert not applied");

  twos_format_a: assert property (
    i_clk_en && i_conv_valid && !cfg_ff.invert && fmt_eff == adcoc_pkg::FMT_TWOS
      && cfg_ff.test == adcoc_pkg::TEST_MID |=> o_data == `ADCOC_W_NEG_FS)
    else $error("twos complement midscale wrong");

  clk_polarity_a: assert property (
    i_clk_en && !i_conv_valid && cfg_ff.clk_inv |=> o_data_output_clock)
    else $error("output clock polarity wrong");

  vref_write_a: assert property (
    i_clk_en && i_req.wr && i_req.addr == `ADCOC_ADDR_VREF
      |=> o_vref_sel == $past(i_req.wdata[`ADCOC_VREF_MSB:`ADCOC_VREF_LSB]))
    else $error("reference select not stored");

  pin_format_a: assert property (
    i_clk_en && i_conv_valid && pin_mode && fsel_pin && !cfg_ff.invert
      && cfg_ff.test == adcoc_pkg::TEST_NEGFS |=> o_data == `ADCOC_W_MID)
    else $error("pin mode format ignored");

  open_bits_a: assert property (
    i_clk_en && i_req.rd && i_req.addr == `ADCOC_ADDR_PHASE |=> o_reg_rdata[6:0] == 7'h00)
    else $error("open bits read nonzero");

endmodule : adcoc_top

// *** adcoc_regs.svh ***
`ifndef ADCOC_REGS_SVH
`define ADCOC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADCOC_ADDR_TEST       8'h0d
`define ADCOC_ADDR_OFFSET     8'h10
`define ADCOC_ADDR_FORMAT     8'h14
`define ADCOC_ADDR_PHASE      8'h16
`define ADCOC_ADDR_VREF       8'h18

// ****************************************
// Reset values and writable bit masks
// ****************************************
`define ADCOC_RST_TEST        8'h00
`define ADCOC_RST_OFFSET      8'h00
`define ADCOC_RST_FORMAT      8'h00
`define ADCOC_RST_PHASE       8'h00
`define ADCOC_RST_VREF        8'hc0
`define ADCOC_MASK_TEST       8'h37
`define ADCOC_MASK_OFFSET     8'h3f
`define ADCOC_MASK_FORMAT     8'hd7
`define ADCOC_MASK_PHASE      8'h80
`define ADCOC_MASK_VREF       8'hc0

// ****************************************
// Field positions
// ****************************************
`define ADCOC_TEST_LONG_RST   5
`define ADCOC_TEST_SHORT_RST  4
`define ADCOC_TEST_MODE_MSB   2
`define ADCOC_OFS_MSB         5
`define ADCOC_DRV_MSB         7
`define ADCOC_DRV_LSB         6
`define ADCOC_DIS_BIT         4
`define ADCOC_INV_BIT         2
`define ADCOC_FMT_MSB         1
`define ADCOC_POL_BIT         7
`define ADCOC_VREF_MSB        7
`define ADCOC_VREF_LSB        6

// ****************************************
// Data words and pattern constants
// ****************************************
`define ADCOC_DATA_W          14
`define ADCOC_W_MID           14'h2000
`define ADCOC_W_POS_FS        14'h3fff
`define ADCOC_W_NEG_FS        14'h0000
`define ADCOC_W_CHK_A         14'h2aaa
`define ADCOC_W_CHK_B         14'h1555
`define ADCOC_SUM_MAX         16'sh3fff
`define ADCOC_SUM_MIN         16'sh0000
`define ADCOC_LONG_LEN        23
`define ADCOC_LONG_TAP        18
`define ADCOC_SHORT_LEN       9
`define ADCOC_SHORT_TAP       5

`endif

// *** adcoc_pkg.sv ***
`include "adcoc_regs.svh"

package adcoc_pkg;

  // Global test field codes
  typedef enum logic [2:0] {
    TEST_OFF   = 3'h0,
    TEST_MID   = 3'h1,
    TEST_POSFS = 3'h2,
    TEST_NEGFS = 3'h3,
    TEST_CHK   = 3'h4,
    TEST_LONG  = 3'h5,
    TEST_SHORT = 3'h6,
    TEST_TOG   = 3'h7
  } adcoc_test_t;

  // Output data format codes
  typedef enum logic [1:0] {
    FMT_OFFS = 2'h0,
    FMT_TWOS = 2'h1,
    FMT_GRAY = 2'h2,
    FMT_RSVD = 2'h3
  } adcoc_fmt_t;

  // Configuration held by the register bank
  typedef struct packed {
    logic        long_rst;
    logic        short_rst;
    adcoc_test_t test;
    logic [5:0]  offset;
    logic [1:0]  drv_cfg;
    logic        out_dis;
    logic        invert;
    adcoc_fmt_t  fmt;
    logic        clk_inv;
    logic [1:0]  vref_sel;
  } adcoc_cfg_t;

  // Register access from the serial port shift register
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcoc_req_t;

endpackage : adcoc_pkg

// *** adcoc_prbs.sv ***
module adcoc_prbs #(
  parameter int unsigned LEN   = 9,
  parameter int unsigned TAP   = 5,
  parameter int unsigned OUT_W = 14
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_clk_en,
  // Control
  input  wire logic             i_step,
  input  wire logic             i_hold,
  // Pattern word
  output logic [OUT_W-1:0]      o_word
);

  logic [LEN-1:0]   state_ff;
  logic [LEN-1:0]   nxt_state;
  logic [OUT_W-1:0] word_ff;
  logic [OUT_W-1:0] nxt_word;
  logic [LEN-1:0]   st;
  logic [OUT_W-1:0] w;
  logic             fb;

  // Advance the register by one output word per sample
  always_comb begin
    st = state_ff;
    w  = word_ff;
    fb = 1'b0;
    for (int i = 0; i < OUT_W; i++) begin
      fb = st[LEN-1] ^ st[TAP-1];
      w  = {w[OUT_W-2:0], fb};
      st = {st[LEN-2:0], fb};
    end
    nxt_state = state_ff;
    nxt_word  = word_ff;
    if (i_hold) begin
      nxt_state = '1;
      nxt_word  = '0;
    end else if (i_step) begin
      nxt_state = st;
      nxt_word  = w;
    end
  end

  // All-ones seed; an all-zero state would lock up
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= '1;
      word_ff  <= '0;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
      word_ff  <= nxt_word;
    end
  end

  assign o_word = word_ff;

endmodule : adcoc_prbs

// *** adcoc_host.sv ***
// ****************************************
// Serial port host model: programs the register bank
// ****************************************
module adcoc_host (
  // Clock and read data
  input  wire logic                  i_ref_clk,
  input  wire logic [7:0]            i_reg_rdata,
  // Register requests and pin
  output adcoc_pkg::adcoc_req_t      o_req,
  output logic                       o_external_output_enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus; enable pin held high so the disable bit governs outputs
  initial begin
    o_req                        = '0;
    o_external_output_enable_pin = 1'b1;
  end

  // Pin level set by the bench for the pin-low scenario only
  task automatic set_pin(input logic lvl);
    @(negedge i_ref_clk);
    o_external_output_enable_pin = lvl;
  endtask : set_pin

  // One access; released lines show the inverse so stale values never match
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int gap, output logic [7:0] rd);
    repeat (gap) @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_req.wr    = wr;
    o_req.rd    = !wr;
    o_req.addr  = a;
    o_req.wdata = d;
    @(negedge i_ref_clk);
    o_req.wr    = 1'b0;
    o_req.rd    = 1'b0;
    o_req.addr  = ~a;
    o_req.wdata = ~d;
    @(negedge i_ref_clk);
    rd = i_reg_rdata;
  endtask : access
endmodule : adcoc_host

// *** adcoc_top_tb.sv ***
module adcoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  i_ref_clk;
  logic                  i_arst_n;
  logic                  i_clk_en;
  adcoc_pkg::adcoc_req_t i_req;
  logic [7:0]            o_reg_rdata;
  logic                  ext_oe;
  logic                  fmt_pin;
  logic                  pin_mode;
  logic                  i_conv_valid;
  logic [13:0]           i_conv_data;
  logic [13:0]           o_data;
  logic                  o_data_oe;
  logic                  out_clk;
  logic [1:0]            o_drv_cfg;
  logic [1:0]            o_vref_sel;
  int                    fail_count;
  int                    checks;
  int                    seed;
  logic [7:0]            rv;
  logic [5:0]            ofs;
  logic [1:0]            fmt;
  logic                  inv;
  logic [13:0]           d;
  logic [13:0]           w1;
  logic [7:0]            adr [6] = '{8'h0d, 8'h10, 8'h14, 8'h16, 8'h18, 8'h11};
  logic [7:0]            rst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};
  logic [7:0]            msk [6] = '{8'h37, 8'h3f, 8'hd7, 8'h80, 8'hc0, 8'h00};

  adcoc_host u_adcoc_host (
    .i_ref_clk                    (i_ref_clk),
    .i_reg_rdata                  (o_reg_rdata),
    .o_req                        (i_req),
    .o_external_output_enable_pin (ext_oe)
  );

  adcoc_top u_adcoc_top (
    .i_ref_clk                        (i_ref_clk),
    .i_arst_n                         (i_arst_n),
    .i_clk_en                         (i_clk_en),
    .i_req                            (i_req),
    .o_reg_rdata                      (o_reg_rdata),
    .i_external_output_enable_pin     (ext_oe),
    .i_serial_clock_format_select_pin (fmt_pin),
    .i_ext_pin_mode                   (pin_mode),
    .i_conv_valid                     (i_conv_valid),
    .i_conv_data                      (i_conv_data),
    .o_data                           (o_data),
    .o_data_oe                        (o_data_oe),
    .o_data_output_clock              (out_clk),
    .o_drv_cfg                        (o_drv_cfg),
    .o_vref_sel                       (o_vref_sel)
  );

  // 40 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Expected word: saturating offset, fixed patterns, format, invert
  function automatic logic [13:0] expw(input logic [13:0] r, input logic [2:0] t);
    int          s;
    logic [13:0] w;
    s = int'(r) + int'($signed(ofs));
    if (s < 0) s = 0;
    if (s > 16383) s = 16383;
    case (t)
      3'h1:    w = 14'h2000;
      3'h2:    w = 14'h3fff;
      3'h3:    w = 14'h0000;
      default: w = s[13:0];
    endcase
    if (fmt == 2'h1) w = w ^ 14'h2000;
    else if (fmt == 2'h2) w = w ^ (w >> 1);
    return inv ? ~w : w;
  endfunction : expw

  // Bus helpers; random idle gaps make the host sometimes slow
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    u_adcoc_host.access(1'b1, a, v, {$random(seed)} % 3, rv);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    u_adcoc_host.access(1'b0, a, 8'h00, {$random(seed)} % 3, v);
  endtask : rreg

  // One converter sample; output is settled at the following falling edge
  task automatic smp(input logic [13:0] x);
    @(negedge i_ref_clk);
    i_conv_valid = 1'b1;
    i_conv_data  = x;
    @(negedge i_ref_clk);
    i_conv_valid = 1'b0;
    i_conv_data  = ~x;
  endtask : smp

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 28635;
    fail_count = 0;
    checks = 0;
    i_arst_n = 1'b0;
    i_clk_en = 1'b1;
    fmt_pin = 1'b0;
    pin_mode = 1'b0;
    i_conv_valid = 1'b0;
    i_conv_data = 14'h0000;
    ofs = 6'h00;
    fmt = 2'h0;
    inv = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    check("vref_sel", 16'(o_vref_sel), 16'h3);
    // Reset values, writable bits, unmapped place
    for (int i = 0; i < 6; i++) begin
      rreg(adr[i], rv);
      check("reset", 16'(rv), 16'(rst[i]));
      wreg(adr[i], 8'hff);
      if (i == 2) check("drv_cfg", 16'(o_drv_cfg), 16'h3);
      rreg(adr[i], rv);
      check("mask", 16'(rv), 16'(msk[i]));
      wreg(adr[i], rst[i]);
    end
    wreg(8'h18, 8'h40);
    check("vref_sel", 16'(o_vref_sel), 16'h1);
    wreg(8'h18, 8'hc0);
    // Requests with the clock enable low are ignored
    i_clk_en = 1'b0;
    wreg(8'h10, 8'h1f);
    i_clk_en = 1'b1;
    rreg(8'h10, rv);
    check("clk_en", 16'(rv), 16'h0);
    // Reset settings: zero offset passes the sample unchanged
    d = 14'($random(seed));
    smp(d);
    check("zero_ofs", 16'(o_data), 16'(expw(d, 3'h0)));
    // Random offset and invert, format stepped through all four codes, with saturation corners first
    for (int n = 0; n < 40; n++) begin
      ofs = (n == 0) ? 6'h1f : (n == 1) ? 6'h20 : 6'($random(seed));
      fmt = 2'(n % 4);
      inv = 1'($random(seed));
      wreg(8'h10, {2'h0, ofs});
      wreg(8'h14, {5'h00, inv, fmt});
      for (int k = 0; k < 3; k++) begin
        d = (n < 2) ? ((k == 0) ? 14'h3ff0 : 14'h0010) : 14'($random(seed));
        smp(d);
        check("data", 16'(o_data), 16'(expw(d, 3'h0)));
        check("out_clk", 16'(out_clk), 16'h1);
      end
    end
    // Fixed words pass through format and invert
    for (int c = 0; c < 9; c++) begin
      fmt = (c > 5) ? 2'h1 : 2'h0;
      inv = (c > 2 && c < 6);
      wreg(8'h14, {5'h00, inv, fmt});
      wreg(8'h0d, 8'(c % 3 + 1));
      d = 14'($random(seed));
      smp(d);
      check("fixed", 16'(o_data), 16'(expw(d, 3'(c % 3 + 1))));
    end
    // Alternating patterns, plain offset binary
    fmt = 2'h0;
    inv = 1'b0;
    wreg(8'h14, 8'h00);
    for (int t = 4; t < 8; t += 3) begin
      wreg(8'h0d, 8'(t));
      // Two samples back to back; the second word must be the inverse of the first
      @(negedge i_ref_clk);
      i_conv_valid = 1'b1;
      i_conv_data  = 14'h0123;
      @(negedge i_ref_clk);
      w1 = o_data;
      @(negedge i_ref_clk);
      i_conv_valid = 1'b0;
      d = (t == 4) ? 14'h2aaa : 14'h3fff;
      check("alt_first", 16'(w1 === d || w1 === (d ^ 14'h3fff)), 16'h1);
      check("alt_next", 16'(o_data), 16'(w1 ^ 14'h3fff));
    end
    // Generators held at seed give zero, then run
    for (int t = 5; t < 7; t++) begin
      wreg(8'h0d, 8'(t) | ((t == 5) ? 8'h20 : 8'h10));
      smp(14'h1111);
      check("prbs_hold", 16'(o_data), 16'h0);
      wreg(8'h0d, 8'(t));
      // First sample still shows the held word; the long first word is zero
      smp(14'h1111);
      smp(14'h1111);
      w1 = o_data;
      smp(14'h1111);
      check("prbs_run", 16'(o_data !== w1), 16'h1);
    end
    wreg(8'h0d, 8'h00);
    // Output disable bit and the enable pin
    check("oe", 16'(o_data_oe), 16'h1);
    wreg(8'h14, 8'h10);
    check("oe_dis", 16'(o_data_oe), 16'h0);
    wreg(8'h14, 8'h00);
    check("oe_en", 16'(o_data_oe), 16'h1);
    u_adcoc_host.set_pin(1'b0);
    repeat (4) @(negedge i_ref_clk);
    check("oe_pin", 16'(o_data_oe), 16'h0);
    u_adcoc_host.set_pin(1'b1);
    // Inverted output clock polarity
    wreg(8'h16, 8'h80);
    smp(14'h0aaa);
    check("out_clk_inv", 16'(out_clk), 16'h0);
    @(negedge i_ref_clk);
    check("out_clk_idle", 16'(out_clk), 16'h1);
    wreg(8'h16, 8'h00);
    // Pin mode overrides the format field
    wreg(8'h14, 8'h02);
    pin_mode = 1'b1;
    for (int p = 1; p >= 0; p--) begin
      fmt_pin = 1'(p);
      fmt = 2'(p);
      wreg(8'h0d, 8'(p * 3));
      repeat (4) @(negedge i_ref_clk);
      d = 14'($random(seed));
      smp(d);
      check("pin_fmt", 16'(o_data), 16'(expw(d, 3'(p * 3))));
    end
    test_done();
  end

  // Watchdog: far beyond the roughly one thousand cycles the sequence needs
  initial begin
    #(25 * 20000);
    fail_count++;
    test_done();
  end
endmodule : adcoc_top_tb
